// [dmc_pkg.sv]
// shared constants and types for the dac datapath mode control block
package dmc_pkg;
  // register addresses
  localparam logic [4:0] ADDR_MOD = 5'h01;
  localparam logic [4:0] ADDR_IF = 5'h02;
  localparam logic [4:0] ADDR_PLL = 5'h04;
  // values after reset
  localparam logic [7:0] MOD_RESET = 8'h04;
  localparam logic [7:0] IF_RESET = 8'h00;
  localparam logic [7:0] PLL_RESET = 8'h00;
  // field positions, modulation control register
  localparam int INTERP_LSB = 6;
  localparam int MODF_LSB = 4;
  localparam int ZSTUFF_BIT = 3;
  localparam int MIX_BIT = 2;
  localparam int SIGN_BIT = 1;
  // field positions, data interface register
  localparam int FMT_BIT = 7;
  localparam int PORT_BIT = 6;
  localparam int DRV_BIT = 5;
  localparam int EXTCLK_BIT = 3;
  // field positions, pll register
  localparam int PLLEN_BIT = 7;
  // readable bit masks
  localparam logic [7:0] MOD_MASK = 8'hFE;
  localparam logic [7:0] IF_MASK = 8'hE8;
  localparam logic [7:0] PLL_MASK = 8'h80;
  // datapath widths
  localparam int DW = 12;
  localparam int CW = 10;
  localparam int COEF_SHIFT = 8;
  // rotation coefficients scaled by 256
  localparam logic signed [9:0] COEF_ONE = 10'sh100;
  localparam logic signed [9:0] COEF_HALF_ROOT2 = 10'sh0B5;
  localparam logic signed [9:0] COEF_ZERO = 10'sh000;
  // sample saturation limits
  localparam logic signed [11:0] SAT_MAX = 12'sh7FF;
  localparam logic signed [11:0] SAT_MIN = 12'sh800;
  // interpolation rate codes
  typedef enum logic [1:0] {
    INTERP_1X = 2'b00,
    INTERP_2X = 2'b01,
    INTERP_4X = 2'b10,
    INTERP_8X = 2'b11
  } dmc_interp_e;
  // modulation frequency codes
  typedef enum logic [1:0] {
    MODF_NONE = 2'b00,
    MODF_HALF = 2'b01,
    MODF_QUARTER = 2'b10,
    MODF_EIGHTH = 2'b11
  } dmc_modf_e;
endpackage : dmc_pkg

// [dmc_word_clock.sv]
// input word timing: own data clock generator or external clock edge detect
`timescale 1ns/1ps
`default_nettype none
module dmc_word_clock (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // mode
  input wire logic [1:0] div_log2,
  input wire logic ext_mode,
  // data clock pin level
  input wire logic pin_i,
  // results
  output logic word_strobe,
  output logic pin_o
);
  logic [2:0] cnt;
  logic [2:0] last;
  logic [2:0] half;
  logic [2:0] next_cnt;
  logic sync1;
  logic sync2;
  logic sync3;

  // period end and high-phase length for the word divisor
  assign last = 3'((4'h1 << div_log2) - 4'h1);
  assign half = 3'((4'h1 << div_log2) >> 1);
  assign next_cnt = (cnt == last) ? 3'h0 : 3'(cnt + 3'h1);

  // word period counter at sample clock rate
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt <= 3'h0;
    else
      cnt <= next_cnt;
  end

  // generated data clock, high in first half of each word period, toggling every cycle at one sample clock per word
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_o <= 1'b0;
    else if (div_log2 == 2'b00)
      pin_o <= ~pin_o; // one word per cycle: fastest toggle
    else
      pin_o <= (next_cnt < half);
  end

  // external clock synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      sync1 <= pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // one word taken per data clock period, two when the own data clock toggles every cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      word_strobe <= 1'b0;
    else if (ext_mode)
      word_strobe <= sync2 & ~sync3;
    else
      word_strobe <= (next_cnt == 3'h0);
  end
endmodule : dmc_word_clock
`default_nettype wire

// [dmc_datapath_ctrl.sv]
// register set, input capture, interpolation and modulation of the dac datapath
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - interpolation code 00/01/10/11 means 1x, 2x, 4x, 8x
// - modulation code 00 none, 01 fs/2, 10 fs/4, 11 fs/8
// - zero stuffing bit inserts zero samples between input samples
// - mix bit one: I and Q modulated independently after interpolation
// - mix bit zero: I and Q form one complex modulator
// - complex sign zero rotates e^-jwt, one rotates e^+jwt
// - format bit zero two's complement, one offset binary
// - port bit zero: I on port one, Q on port two
// - drive bit selects stronger data clock pin driver
// - pll off and external bit zero: device drives its own data clock
// - generated data clock runs at input word rate, one word per period; at one sample clock per word it toggles each cycle, two words per period
// - pll enabled only when pll enable bit is one
module dmc_datapath_ctrl (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // register port
  input wire logic REG_WE,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // input sample ports
  input wire logic [11:0] PORT1_DATA,
  input wire logic [11:0] PORT2_DATA,
  input wire logic CHANNEL_SELECT_INPUT,
  // data clock pin
  input wire logic SAMPLE_RATE_CLOCK_PIN_I,
  output logic SAMPLE_RATE_CLOCK_PIN_O,
  output logic SAMPLE_RATE_CLOCK_PIN_OE,
  output logic DRIVE_STRONG,
  // pll control
  output logic PLL_ENABLE,
  // dac core samples, two's complement
  output logic [11:0] DAC_I,
  output logic [11:0] DAC_Q
);
  logic [7:0] mod_reg;
  logic [7:0] if_reg;
  logic [7:0] pll_reg;
  logic [1:0] interp;
  logic [1:0] modf;
  logic one_port;
  logic ext_clk;
  logic [1:0] div_log2;
  logic word_strobe;
  logic pin_o;
  logic [11:0] w1;
  logic [11:0] w2;
  logic [11:0] stage_i;
  logic signed [11:0] hold_i;
  logic signed [11:0] hold_q;
  logic fresh;
  logic [2:0] phase;
  logic [2:0] step;
  logic signed [11:0] in_i;
  logic signed [11:0] in_q;
  logic signed [9:0] c;
  logic signed [9:0] s;
  logic signed [22:0] acc_i;
  logic signed [22:0] acc_q;

  // eighth-turn cosine table, scaled by 256
  function automatic logic signed [9:0] cos8(input logic [2:0] k);
    unique case (k)
      3'h0: cos8 = dmc_pkg::COEF_ONE;
      3'h1, 3'h7: cos8 = dmc_pkg::COEF_HALF_ROOT2;
      3'h2, 3'h6: cos8 = dmc_pkg::COEF_ZERO;
      3'h3, 3'h5: cos8 = -dmc_pkg::COEF_HALF_ROOT2;
      3'h4: cos8 = -dmc_pkg::COEF_ONE;
    endcase
  endfunction : cos8

  // clamp a scaled sum back to sample width
  function automatic logic signed [11:0] sat12(input logic signed [22:0] v);
    logic signed [22:0] t;
    t = v >>> dmc_pkg::COEF_SHIFT;
    if (t > 23'(dmc_pkg::SAT_MAX))
      sat12 = dmc_pkg::SAT_MAX;
    else if (t < 23'(dmc_pkg::SAT_MIN))
      sat12 = dmc_pkg::SAT_MIN;
    else
      sat12 = t[11:0];
  endfunction : sat12

  // register writes
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      mod_reg <= dmc_pkg::MOD_RESET;
      if_reg <= dmc_pkg::IF_RESET;
      pll_reg <= dmc_pkg::PLL_RESET;
    end
    else if (REG_WE)
    begin
      unique case (REG_ADDR)
        dmc_pkg::ADDR_MOD: mod_reg <= REG_WDATA & dmc_pkg::MOD_MASK;
        dmc_pkg::ADDR_IF: if_reg <= REG_WDATA & dmc_pkg::IF_MASK;
        dmc_pkg::ADDR_PLL: pll_reg <= REG_WDATA & dmc_pkg::PLL_MASK;
        default: ;
      endcase
    end
  end

  // register read back, unused addresses read zero
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      REG_RDATA <= 8'h00;
    else
      unique case (REG_ADDR)
        dmc_pkg::ADDR_MOD: REG_RDATA <= mod_reg;
        dmc_pkg::ADDR_IF: REG_RDATA <= if_reg;
        dmc_pkg::ADDR_PLL: REG_RDATA <= pll_reg;
        default: REG_RDATA <= 8'h00;
      endcase
  end

  // field decode
  assign interp = mod_reg[dmc_pkg::INTERP_LSB +: 2];
  assign modf = mod_reg[dmc_pkg::MODF_LSB +: 2];
  assign one_port = if_reg[dmc_pkg::PORT_BIT];
  // pll on means data clock options do not apply
  assign ext_clk = if_reg[dmc_pkg::EXTCLK_BIT] & ~pll_reg[dmc_pkg::PLLEN_BIT];

  // sample clocks per word: interpolation factor, halved when interleaved above 1x
  always_comb
  begin
    if (one_port && interp != dmc_pkg::INTERP_1X)
      div_log2 = 2'(interp - 2'b01);
    else
      div_log2 = interp;
  end

  // data clock timing
  dmc_word_clock u_word_clock (
    .clk(CLK),
    .rst(SYS_RST),
    .div_log2(div_log2),
    .ext_mode(ext_clk),
    .pin_i(SAMPLE_RATE_CLOCK_PIN_I),
    .word_strobe(word_strobe),
    .pin_o(pin_o)
  );

  // data clock pin drive, pll enable and driver strength
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      SAMPLE_RATE_CLOCK_PIN_O <= 1'b0;
      SAMPLE_RATE_CLOCK_PIN_OE <= 1'b0;
      DRIVE_STRONG <= 1'b0;
      PLL_ENABLE <= 1'b0;
    end
    else
    begin
      SAMPLE_RATE_CLOCK_PIN_O <= pin_o;
      SAMPLE_RATE_CLOCK_PIN_OE <= ~ext_clk & ~pll_reg[dmc_pkg::PLLEN_BIT];
      DRIVE_STRONG <= if_reg[dmc_pkg::DRV_BIT];
      PLL_ENABLE <= pll_reg[dmc_pkg::PLLEN_BIT];
    end
  end

  // offset binary turns into two's complement by flipping the sign bit
  assign w1 = {PORT1_DATA[11] ^ if_reg[dmc_pkg::FMT_BIT], PORT1_DATA[10:0]};
  assign w2 = {PORT2_DATA[11] ^ if_reg[dmc_pkg::FMT_BIT], PORT2_DATA[10:0]};

  // input capture, dual port or interleaved single port
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      stage_i <= 12'h000;
      hold_i <= 12'sh000;
      hold_q <= 12'sh000;
      fresh <= 1'b0;
    end
    else
    begin
      fresh <= 1'b0;
      if (word_strobe && !one_port)
      begin
        hold_i <= w1;
        hold_q <= w2;
        fresh <= 1'b1;
      end
      else if (word_strobe && !CHANNEL_SELECT_INPUT)
        stage_i <= w1;
      else if (word_strobe)
      begin
        hold_i <= stage_i;
        hold_q <= w1;
        fresh <= 1'b1;
      end
    end
  end

  // zero stuffing keeps the new sample for one cycle only
  assign in_i = (fresh || !mod_reg[dmc_pkg::ZSTUFF_BIT]) ? hold_i : 12'sh000;
  assign in_q = (fresh || !mod_reg[dmc_pkg::ZSTUFF_BIT]) ? hold_q : 12'sh000;

  // phase step per sample clock for the modulation frequency
  always_comb
  begin
    unique case (modf)
      dmc_pkg::MODF_NONE: step = 3'h0;
      dmc_pkg::MODF_HALF: step = 3'h4;
      dmc_pkg::MODF_QUARTER: step = 3'h2;
      dmc_pkg::MODF_EIGHTH: step = 3'h1;
    endcase
  end

  // modulation phase, parked at zero when modulation is off
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || modf == dmc_pkg::MODF_NONE)
      phase <= 3'h0;
    else
      phase <= 3'(phase + step);
  end

  // rotation coefficients shared by both channels
  assign c = cos8(phase);
  assign s = cos8(3'(phase - 3'h2));

  // real or complex mixing
  always_comb
  begin
    if (mod_reg[dmc_pkg::MIX_BIT])
    begin
      // operands widened first so the product keeps all its bits
      acc_i = 23'(in_i) * 23'(c);
      acc_q = 23'(in_q) * 23'(c);
    end
    else if (!mod_reg[dmc_pkg::SIGN_BIT])
    begin
      acc_i = 23'(in_i) * 23'(c) + 23'(in_q) * 23'(s);
      acc_q = 23'(in_q) * 23'(c) - 23'(in_i) * 23'(s);
    end
    else
    begin
      acc_i = 23'(in_i) * 23'(c) - 23'(in_q) * 23'(s);
      acc_q = 23'(in_q) * 23'(c) + 23'(in_i) * 23'(s);
    end
  end

  // dac sample registers
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      DAC_I <= 12'h000;
      DAC_Q <= 12'h000;
    end
    else
    begin
      DAC_I <= sat12(acc_i);
      DAC_Q <= sat12(acc_q);
    end
  end
endmodule : dmc_datapath_ctrl
`default_nettype wire

// [dmc_datapath_ctrl_monitor.sv]
// port assertions for the datapath mode control block
`timescale 1ns/1ps
`default_nettype none
module dmc_datapath_ctrl_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // register port
  input wire logic REG_WE,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // pin and core outputs
  input wire logic SAMPLE_RATE_CLOCK_PIN_O,
  input wire logic SAMPLE_RATE_CLOCK_PIN_OE,
  input wire logic DRIVE_STRONG,
  input wire logic PLL_ENABLE,
  input wire logic [11:0] DAC_I,
  input wire logic [11:0] DAC_Q
);
  // one clock domain for every check
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // write, then an idle cycle at the same address
  sequence s_wr(a);
    REG_WE && REG_ADDR == a ##1 !REG_WE && REG_ADDR == a;
  endsequence
  property p_mod_rd;
    s_wr(5'h01) |=> REG_RDATA == ($past(REG_WDATA, 2) & dmc_pkg::MOD_MASK);
  endproperty
  a_mod_rd: assert property (p_mod_rd) else $error("mod readback");
  property p_unmapped;
    REG_ADDR == 5'h03 |=> REG_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_drv;
    s_wr(5'h02) |=> DRIVE_STRONG == $past(REG_WDATA[5], 2);
  endproperty
  a_drv: assert property (p_drv) else $error("driver select");
  property p_pll;
    s_wr(dmc_pkg::ADDR_PLL) |=> PLL_ENABLE == $past(REG_WDATA[7], 2);
  endproperty
  a_pll: assert property (p_pll) else $error("pll enable");
  property p_pll_oe;
    PLL_ENABLE [*3] |-> !SAMPLE_RATE_CLOCK_PIN_OE;
  endproperty
  a_pll_oe: assert property (p_pll_oe) else $error("pin driven with pll");
  property p_clk_hi;
    $rose(SAMPLE_RATE_CLOCK_PIN_O) |-> ##[1:4] !SAMPLE_RATE_CLOCK_PIN_O;
  endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("data clock high");
  property p_clk_lo;
    $fell(SAMPLE_RATE_CLOCK_PIN_O) && SAMPLE_RATE_CLOCK_PIN_OE
      |-> ##[1:4] (SAMPLE_RATE_CLOCK_PIN_O || !SAMPLE_RATE_CLOCK_PIN_OE);
  endproperty
  a_clk_lo: assert property (p_clk_lo) else $error("data clock low");
  property p_rst;
    $fell(SYS_RST) |-> DAC_I == 12'h000 && DAC_Q == 12'h000 && !PLL_ENABLE;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
endmodule : dmc_datapath_ctrl_monitor
// attach the checks to the block
bind dmc_datapath_ctrl dmc_datapath_ctrl_monitor u_mon (.CLK(CLK), .SYS_RST(SYS_RST),
  .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .SAMPLE_RATE_CLOCK_PIN_O(SAMPLE_RATE_CLOCK_PIN_O),
  .SAMPLE_RATE_CLOCK_PIN_OE(SAMPLE_RATE_CLOCK_PIN_OE), .DRIVE_STRONG(DRIVE_STRONG),
  .PLL_ENABLE(PLL_ENABLE), .DAC_I(DAC_I), .DAC_Q(DAC_Q));
`default_nettype wire

// [dmc_src_model.sv]
// baseband word source driving the sample ports
`timescale 1ns/1ps
`default_nettype none
module dmc_src_model (
  // clock and setup
  input wire logic clk,
  input wire logic one_port,
  input wire logic ext_clk,
  input wire logic [11:0] i_word,
  input wire logic [11:0] q_word,
  // pins
  input wire logic pin,
  output logic drv,
  output logic sel,
  output logic [11:0] port1,
  output logic [11:0] port2
);
  logic [2:0] cnt = 3'h0;
  logic prev = 1'b0;
  logic ph = 1'b0;
  // next word on each rise of the data clock pin
  always_ff @(posedge clk)
  begin
    cnt <= cnt + 3'h1;
    prev <= pin;
    if (pin && !prev)
      ph <= ~ph;
  end
  // own data clock, eight sample clocks a word
  assign drv = ext_clk & ~cnt[2];
  // interleaved words on port one, port two toggling
  assign sel = one_port & ph;
  assign port1 = sel ? q_word : i_word;
  assign port2 = one_port ? ~port1 : q_word;
endmodule : dmc_src_model
`default_nettype wire

// [dac_datapath_mode_control_tb.sv]
// self-checking bench for the datapath mode control block
`timescale 1ns/1ps
`default_nettype none
module dac_datapath_mode_control_tb;
  logic clk, rst, we, one, ext, sel, pin, drv, po, oe, ds, pe;
  logic [4:0] addr;
  logic [7:0] wd, rdata;
  logic [11:0] p1, p2, iw, qw, di, dq;
  int n_errors = 0;
  int num_checks = 0;
  int seed = 32'h1d7ef7cf;
  // device, far side and shared data clock pin
  dmc_datapath_ctrl dut (.CLK(clk), .SYS_RST(rst), .REG_WE(we), .REG_ADDR(addr),
    .REG_WDATA(wd), .REG_RDATA(rdata), .PORT1_DATA(p1), .PORT2_DATA(p2),
    .CHANNEL_SELECT_INPUT(sel), .SAMPLE_RATE_CLOCK_PIN_I(pin),
    .SAMPLE_RATE_CLOCK_PIN_O(po), .SAMPLE_RATE_CLOCK_PIN_OE(oe), .DRIVE_STRONG(ds),
    .PLL_ENABLE(pe), .DAC_I(di), .DAC_Q(dq));
  dmc_src_model src (.clk(clk), .one_port(one), .ext_clk(ext), .i_word(iw),
    .q_word(qw), .pin(pin), .drv(drv), .sel(sel), .port1(p1), .port2(p2));
  assign pin = oe ? po : drv;
  // 40 MHz sample clock
  initial
  begin
    clk = 1'b0;
    forever
      #12.5 clk = ~clk;
  end
  // count one comparison
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    we = 1'b1;
    tick(1);
    we = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    addr = a;
    tick(2);
    chk(rdata === e, "read value");
  endtask : rd
  // expected next pair of a quarter-rate complex rotation
  function automatic logic [23:0] rot(input logic [11:0] a, b, input logic s);
    return s ? {-b, a} : {b, -a};
  endfunction : rot
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // main sequence
  initial
  begin
    logic [23:0] sv[16];
    int j;
    rst = 1'b1;
    we = 1'b0;
    addr = 5'h00;
    wd = 8'h00;
    one = 1'b0;
    ext = 1'b0;
    iw = 12'h001;
    qw = 12'h001;
    tick(20);
    rst = 1'b0;
    tick(1);
    rd(5'h01, 8'h04);
    rd(5'h02, 8'h00);
    chk(oe === 1'b1, "own clock drive");
    wr(5'h01, 8'hFF);
    rd(5'h01, 8'hFE);
    wr(5'h02, 8'hFF);
    chk(ds === 1'b1, "strong driver");
    rd(5'h02, 8'hE8);
    wr(dmc_pkg::ADDR_PLL, 8'hFF);
    tick(3);
    chk(pe === 1'b1 && oe === 1'b0, "pll on");
    rd(dmc_pkg::ADDR_PLL, 8'h80);
    wr(5'h03, 8'hFF);
    rd(5'h03, 8'h00);
    wr(dmc_pkg::ADDR_PLL, 8'h00);
    wr(5'h02, 8'h00);
    tick(3);
    chk(ds === 1'b0 && oe === 1'b1, "own clock again");
    $display("registers done");
    for (int k = 0; k < 4; k++)
    begin
      iw = 12'($random(seed)) | 12'h001;
      qw = 12'($random(seed)) | 12'h001;
      wr(5'h02, {k[0], 7'h00});
      wr(5'h01, 8'h04);
      tick(8);
      chk(di === (k[0] ? iw ^ 12'h800 : iw) && dq === (k[0] ? qw ^ 12'h800 : qw), "format");
    end
    // back to two's complement so the mixing checks see the raw words
    wr(5'h02, 8'h00);
    for (int m = 1; m < 4; m++)
    begin
      wr(5'h01, {2'b00, m[1:0], 4'b0100});
      for (int t = 0; t < 16; t++)
      begin
        sv[t] = {di, dq};
        tick(1);
      end
      j = 0;
      while (j < 8 && sv[j] !== {iw, qw})
        j++;
      chk(sv[j + (1 << m) / 2] === {-iw, -qw} && sv[j + (1 << m)] === {iw, qw}, "real mix");
    end
    for (int s = 0; s < 2; s++)
    begin
      wr(5'h01, 8'h04);
      wr(5'h01, {6'b001000, s[0], 1'b0});
      for (int t = 0; t < 4; t++)
      begin
        sv[0] = {di, dq};
        tick(1);
        chk({di, dq} === rot(sv[0][23:12], sv[0][11:0], s[0]), "complex mix");
      end
    end
    $display("modulation done");
    for (int it = 0; it < 4; it++)
    begin
      wr(5'h01, {it[1:0], 6'b001100});
      // let the word divider and the phase settle before counting
      tick(16);
      j = 0;
      for (int t = 0; t < 32; t++)
      begin
        j += int'(di !== 12'h000);
        tick(1);
      end
      chk(j == (32 >> it), "zero stuff count");
    end
    $display("rates done");
    one = 1'b1;
    wr(5'h01, 8'hC4);
    wr(5'h02, 8'h40);
    tick(40);
    chk(di === iw && dq === qw, "one port pairing");
    ext = 1'b1;
    wr(5'h02, 8'h48);
    tick(60);
    chk(di === iw && dq === qw && oe === 1'b0, "external clock");
    $display("one port done");
    wrap_up;
  end
endmodule : dac_datapath_mode_control_tb
`default_nettype wire
